// [hdl/fast_pulse_counter.sv]
// gated pulse counter with reload, preset compare and match output
// assumes control inputs come from logic on clk; pulse_in is an async pin
module fast_pulse_counter #(
	parameter int COUNT_W = pulse_counter_pkg::COUNT_W_DEF,
	parameter int PRESET_NUM = pulse_counter_pkg::PRESET_NUM_DEF,
	parameter int GROUP_MAX = pulse_counter_pkg::GROUP_MAX_DEF,
	parameter int GROUP_SELECT = pulse_counter_pkg::GROUP_SELECT_DEF,
	parameter int SCAN_CYCLES = pulse_counter_pkg::SCAN_CYCLES_DEF,
	parameter bit RELOAD_CONNECTED = 1'b1,
	parameter bit CLEAR_CONNECTED = 1'b1,
	parameter int IDX_W = (PRESET_NUM > 1) ? $clog2(PRESET_NUM) : 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pulse_in,
	input wire logic count_gate,
	input wire logic count_reload,
	input wire logic compare_out_clear,
	input wire logic compare_enable,
	input wire logic [GROUP_MAX-1:0] group_configured,
	input wire logic [COUNT_W-1:0] reset_value,
	input wire logic preset_wr,
	input wire logic [IDX_W-1:0] preset_wr_idx,
	input wire logic [COUNT_W-1:0] preset_wr_data,
	input wire logic next_preset_wr,
	input wire logic [IDX_W-1:0] next_preset_wr_data,
	output logic [COUNT_W-1:0] count_value,
	output logic match_pulse,
	output logic ext_compare_out,
	output logic [IDX_W-1:0] current_preset_num,
	output logic [IDX_W-1:0] next_preset_num,
	output logic scan_tick
);

	initial begin
		if (GROUP_SELECT < 1 || GROUP_SELECT > GROUP_MAX)
			$error("group select out of range");
		if (SCAN_CYCLES < 2 || PRESET_NUM < 1 || COUNT_W < 2)
			$error("unsupported counter parameters");
		if (IDX_W < 1 || (1 << IDX_W) < PRESET_NUM || GROUP_MAX < 1)
			$error("index width cannot address every preset");
	end

	function automatic logic [IDX_W-1:0] idx_after(
		input logic [IDX_W-1:0] idx);
		if (idx >= IDX_W'(PRESET_NUM - 1))
			idx_after = '0;
		else
			idx_after = IDX_W'(idx + 1'b1);
	endfunction

	logic pulse_meta_reg;
	logic pulse_sync_reg;
	logic pulse_prev_reg;
	logic pulse_edge;
	logic [31:0] scan_cnt_reg;
	logic [COUNT_W-1:0] preset_mem [PRESET_NUM];
	logic [COUNT_W-1:0] active_preset;
	logic [COUNT_W-1:0] count_next;
	logic reload_eff;
	logic clear_eff;
	logic operate;
	logic counting;
	logic hit;
	logic match_pending_reg;

	// an unconnected input is tied off at elaboration, never left floating
	assign reload_eff = RELOAD_CONNECTED & count_reload;
	assign clear_eff = CLEAR_CONNECTED & compare_out_clear;
	// only the selected group, and only if configured, may run
	assign operate = group_configured[GROUP_SELECT - 1];
	assign counting = operate & count_gate & ~reload_eff & pulse_edge;
	assign count_next = COUNT_W'(count_value + 1'b1);
	assign active_preset = preset_mem[current_preset_num];
	// equality checked on the counted edge only, so a parked count
	// cannot re-fire the output scan after scan
	assign hit = counting & compare_enable & (count_next == active_preset);

	// two flops before the edge detector looks at the pin
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pulse_meta_reg <= 1'b0;
			pulse_sync_reg <= 1'b0;
			pulse_prev_reg <= 1'b0;
		end else begin
			pulse_meta_reg <= pulse_in;
			pulse_sync_reg <= pulse_meta_reg;
			pulse_prev_reg <= pulse_sync_reg;
		end
	end
	assign pulse_edge = pulse_sync_reg & ~pulse_prev_reg;

	// scan divider, one-cycle enable per scan
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scan_cnt_reg <= '0;
			scan_tick <= 1'b0;
		end else if (scan_cnt_reg == 32'(SCAN_CYCLES - 1)) begin
			scan_cnt_reg <= '0;
			scan_tick <= 1'b1;
		end else begin
			scan_cnt_reg <= scan_cnt_reg + 32'h1;
			scan_tick <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_value <= COUNT_W'(pulse_counter_pkg::COUNT_RESET);
		end else if (operate && reload_eff) begin
			count_value <= reset_value;
		end else if (counting) begin
			count_value <= count_next;
		end
		// gate off and no reload: value simply held
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < PRESET_NUM; i++)
				preset_mem[i] <= '0;
		end else if (preset_wr) begin
			preset_mem[preset_wr_idx] <= preset_wr_data;
		end
	end

	// a software write to the next number beats the auto-advance
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			current_preset_num <= '0;
			next_preset_num <= IDX_W'(PRESET_NUM > 1 ? 1 : 0);
		end else begin
			if (hit)
				current_preset_num <= next_preset_num;
			if (next_preset_wr)
				next_preset_num <= next_preset_wr_data;
			else if (hit)
				next_preset_num <= idx_after(next_preset_num);
		end
	end

	// a hit in the tick cycle goes straight into the output below, so the
	// tick always empties the flag and one hit never spans two scans
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			match_pending_reg <= 1'b0;
		end else if (!count_gate || !compare_enable) begin
			match_pending_reg <= 1'b0;
		end else if (scan_tick) begin
			match_pending_reg <= 1'b0;
		end else if (hit) begin
			match_pending_reg <= 1'b1;
		end
	end

	// output loads on scan boundaries and stands a whole scan, but gate off or compare off clears it at once
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			match_pulse <= 1'b0;
		end else if (!count_gate || !compare_enable) begin
			match_pulse <= 1'b0;
		end else if (scan_tick) begin
			match_pulse <= match_pending_reg | hit;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ext_compare_out <= 1'b0;
		end else if (clear_eff) begin
			ext_compare_out <= 1'b0;
		end else if (hit) begin
			ext_compare_out <= 1'b1;
		end
	end

	sequence match_launch_s;
		scan_tick && count_gate && compare_enable && (match_pending_reg || hit);
	endsequence

	sequence match_held_s;
		match_pulse && !scan_tick;
	endsequence

	property match_one_scan_p;
		@(posedge clk) disable iff (sys_rst)
		match_launch_s |=> match_pulse;
	endproperty

	property match_from_tick_p;
		@(posedge clk) disable iff (sys_rst)
		$rose(match_pulse) |-> $past(scan_tick) && $past(count_gate);
	endproperty

	property match_hold_p;
		@(posedge clk) disable iff (sys_rst)
		match_held_s ##0 (count_gate && compare_enable) |=> match_pulse;
	endproperty

	match_launch_a: assert property (match_one_scan_p)
		else $error("match not launched on scan tick");
	match_rise_a: assert property (match_from_tick_p)
		else $error("match rose off a scan boundary");
	match_hold_a: assert property (match_hold_p)
		else $error("match dropped inside its scan");

	gate_low_match_a: assert property (@(posedge clk) disable iff (sys_rst)
		!count_gate |=> !match_pulse)
		else $error("match high with gate off");

	compare_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		!compare_enable |=> !match_pulse)
		else $error("match high with compare disabled");

	clear_out_a: assert property (@(posedge clk) disable iff (sys_rst)
		clear_eff |=> !ext_compare_out)
		else $error("external output high during clear");

	reload_load_a: assert property (@(posedge clk) disable iff (sys_rst)
		operate && reload_eff |=> count_value == $past(reset_value))
		else $error("reload did not load reset value");

	gate_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!count_gate && !reload_eff |=> $stable(count_value))
		else $error("count moved with gate off");

	count_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		operate && count_gate && !reload_eff && pulse_edge
		|=> count_value == COUNT_W'($past(count_value) + 1'b1))
		else $error("counted pulse not added");

	idle_group_a: assert property (@(posedge clk) disable iff (sys_rst)
		!operate |=> $stable(count_value))
		else $error("unconfigured group counted");

	next_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		next_preset_wr |=> next_preset_num == $past(next_preset_wr_data))
		else $error("software next number lost");

	preset_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		hit |=> current_preset_num == $past(next_preset_num))
		else $error("preset number did not advance");

	sequence match_end_s;
		scan_tick && match_pulse && !match_pending_reg && !hit;
	endsequence

	match_end_a: assert property (@(posedge clk) disable iff (sys_rst)
		match_end_s |=> !match_pulse)
		else $error("match outlived its scan");

	pend_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		scan_tick |=> !match_pending_reg)
		else $error("pending match kept past a scan tick");

	tick_single_a: assert property (@(posedge clk) disable iff (sys_rst)
		scan_tick |=> !scan_tick)
		else $error("scan tick longer than one cycle");

	ext_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		hit && !clear_eff |=> ext_compare_out)
		else $error("external output not set on match");

	ext_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!clear_eff && !hit |=> $stable(ext_compare_out))
		else $error("external output moved without cause");

	match_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(match_pulse) |-> $past(match_pending_reg) || $past(hit))
		else $error("match rose without an equal count");

	reload_first_a: assert property (@(posedge clk) disable iff (sys_rst)
		operate && reload_eff && count_gate && pulse_edge
		|=> count_value == $past(reset_value))
		else $error("pulse counted during reload");

	gate_off_cmp_a: assert property (@(posedge clk) disable iff (sys_rst)
		!count_gate && !next_preset_wr
		|=> $stable(current_preset_num) && $stable(next_preset_num))
		else $error("compare ran with gate off");

	idle_cmp_a: assert property (@(posedge clk) disable iff (sys_rst)
		!operate |=> $stable(current_preset_num))
		else $error("unconfigured group compared");

	next_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		hit && !next_preset_wr
		|=> next_preset_num == idx_after($past(next_preset_num)))
		else $error("next number did not advance");

endmodule

// [hdl/pulse_counter_pkg.sv]
// constants shared by the gated pulse counter and its bench
// assumes a single 25 MHz system clock and a scan-driven control program
package pulse_counter_pkg;
	localparam int CLK_MHZ = 25;
	// scan period in microseconds, scan rate of the control program
	localparam int SCAN_TIME_US = 1000;
	localparam int SCAN_CYCLES_DEF = SCAN_TIME_US * CLK_MHZ;
	localparam int COUNT_W_DEF = 32;
	localparam int PRESET_NUM_DEF = 4;
	localparam int GROUP_MAX_DEF = 6;
	localparam int GROUP_SELECT_DEF = 1;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
endpackage

// [testbench/pulse_source.sv]
// external pulse source driving the counter's pulse pin
// assumes clk is the counter clock; the pin idles low between bursts
module pulse_source (
	input wire logic clk,
	output logic pulse_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pulse_in = 1'b0;
	// 3 clocks high and at least 3 low, above the synchroniser minimum
	task automatic send(input int n);
		repeat (n) begin
			@(negedge clk) pulse_in = 1'b1;
			repeat (3) @(negedge clk);
			pulse_in = 1'b0;
			repeat (3) @(negedge clk);
		end
		repeat (4) @(negedge clk);
	endtask
endmodule

// [testbench/tb.sv]
// self-checking bench for the gated pulse counter
// assumes a scan of 8 clocks; control program modelled by tasks below
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SCAN = 8;
	logic clk, sys_rst, pulse_in, count_gate, count_reload;
	logic compare_out_clear, compare_enable, preset_wr;
	logic next_preset_wr;
	logic [5:0] group_configured;
	logic [31:0] reset_value, preset_wr_data, count_value;
	logic [1:0] preset_wr_idx, next_preset_wr_data;
	logic [1:0] current_preset_num, next_preset_num;
	logic match_pulse, ext_compare_out, scan_tick;
	int fail_count = 0, cmp_count = 0, cyc = 0, run = 0, last_run = 0;
	int tick_last = 0, tick_gap = 0;
	always #20 clk = ~clk;
	pulse_source u_src (.clk(clk), .pulse_in(pulse_in));
	fast_pulse_counter #(.SCAN_CYCLES(SCAN)) u_dut (.clk(clk),
		.sys_rst(sys_rst),
		.pulse_in(pulse_in), .count_gate(count_gate),
		.count_reload(count_reload), .compare_out_clear(compare_out_clear),
		.compare_enable(compare_enable), .group_configured(group_configured),
		.reset_value(reset_value), .preset_wr(preset_wr),
		.preset_wr_idx(preset_wr_idx), .preset_wr_data(preset_wr_data),
		.next_preset_wr(next_preset_wr),
		.next_preset_wr_data(next_preset_wr_data), .count_value(count_value),
		.match_pulse(match_pulse), .ext_compare_out(ext_compare_out),
		.current_preset_num(current_preset_num),
		.next_preset_num(next_preset_num), .scan_tick(scan_tick));
	// length of the last match pulse, in clocks
	always @(posedge clk) begin
		cyc++;
		if (match_pulse === 1'b1) run++;
		else if (run != 0) begin last_run = run; run = 0; end
		// spacing of scan ticks, in clocks
		if (scan_tick === 1'b1) begin
			if (tick_last != 0)
				tick_gap = cyc - tick_last;
			tick_last = cyc;
		end
		if (cyc == 5000) begin fail_count++; report_and_stop(); end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic set_preset(input logic [1:0] i, input logic [31:0] v);
		@(negedge clk) begin preset_wr = 1; preset_wr_idx = i; end
		preset_wr_data = v;
		@(negedge clk) preset_wr = 0;
	endtask
	task automatic reload(input logic [31:0] v);
		@(negedge clk) begin reset_value = v; count_reload = 1; end
		@(negedge clk) count_reload = 0;
	endtask
	// control levels of the scan program, applied in the current time step
	task automatic drive(input logic g, input logic r, input logic c,
		input logic e, input logic [5:0] grp);
		count_gate = g;
		count_reload = r;
		compare_out_clear = c;
		compare_enable = e;
		group_configured = grp;
	endtask
	task automatic set_next(input logic [1:0] n);
		@(negedge clk) next_preset_wr = 1'b1;
		next_preset_wr_data = n;
		@(negedge clk) next_preset_wr = 1'b0;
	endtask
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		drive(1'b0, 1'b0, 1'b0, 1'b1, 6'h01);
		reset_value = '0;
		preset_wr = 1'b0;
		preset_wr_idx = '0;
		preset_wr_data = '0;
		next_preset_wr = 1'b0;
		next_preset_wr_data = '0;
		repeat (6) @(negedge clk);
		sys_rst = 1'b0;
		`CHK(count_value, 32'h0)
		`CHK(next_preset_num, 2'h1)
		set_preset(2'h0, 32'h0000_000a);
		set_preset(2'h1, 32'h0000_000c);
		set_preset(2'h3, 32'h0000_000e);
		reload(32'h5);
		@(negedge clk) `CHK(count_value, 32'h5)
		u_src.send(2);
		`CHK(count_value, 32'h5)
		drive(1'b1, 1'b0, 1'b0, 1'b1, 6'h01);
		u_src.send(3);
		`CHK(count_value, 32'h8)
		$display("test count done");
		u_src.send(2);
		`CHK(ext_compare_out, 1'b1)
		`CHK(current_preset_num, 2'h1)
		`CHK(next_preset_num, 2'h2)
		repeat (20) @(negedge clk);
		`CHK(last_run, SCAN)
		`CHK(tick_gap, SCAN)
		`CHK(match_pulse, 1'b0)
		drive(1'b1, 1'b0, 1'b1, 1'b1, 6'h01);
		@(negedge clk) `CHK(ext_compare_out, 1'b0)
		drive(1'b1, 1'b0, 1'b0, 1'b1, 6'h01);
		set_next(2'h3);
		`CHK(next_preset_num, 2'h3)
		u_src.send(2);
		`CHK(current_preset_num, 2'h3)
		$display("test match done");
		repeat (20) @(negedge clk);
		// reload held across a pulse with the gate on
		reset_value = 32'hd;
		drive(1'b1, 1'b1, 1'b0, 1'b1, 6'h01);
		u_src.send(1);
		drive(1'b1, 1'b0, 1'b0, 1'b1, 6'h01);
		`CHK(count_value, 32'hd)
		fork
			u_src.send(1);
			begin
				for (int i = 0; i < 40 && match_pulse !== 1'b1; i++)
					@(negedge clk);
				drive(1'b0, 1'b0, 1'b0, 1'b1, 6'h01);
				@(negedge clk) `CHK(match_pulse, 1'b0)
			end
		join
		`CHK(count_value, 32'he)
		u_src.send(1);
		`CHK(count_value, 32'he)
		$display("test gate done");
		drive(1'b1, 1'b0, 1'b0, 1'b0, 6'h01);
		last_run = 0;
		reload(32'h8);
		u_src.send(2);
		repeat (20) @(negedge clk);
		`CHK(last_run, 0)
		`CHK(match_pulse, 1'b0)
		drive(1'b1, 1'b0, 1'b0, 1'b0, 6'h00);
		u_src.send(2);
		`CHK(count_value, 32'ha)
		reload(32'h3);
		@(negedge clk) `CHK(count_value, 32'ha)
		$display("test disable done");
		report_and_stop();
	end
endmodule
